// file: hdl/ctud_core_timer.sv
// Purpose: core 16-bit up/down timer with overflow toggle latch
// Assumes: axi4-lite slave, inputs synchronous to mclk
// Notes: one write and one read under way at a time
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.

// Summary of operation
// - software direction bit: 0 up, 1 down
// - run bit 0 stops, 1 runs
// - mode field decodes timer, counter, gated modes
// - run bit honoured in every mode
// - gated: count only with run and gate
// - code 010 low enables, 011 high enables
// - mode bit 3 picks gate level
// - remote select lets run bit drive aux
// - external pin sets direction, xor software bit
// - direction changes apply immediately
// - wrap toggles latch, shadow follows one cycle
// - latch and shadow routed to aux input
// - software write loads both latches together
// - output pin shows latch or high
// - wrap pulse output for capture/compare timers
// - timer mode: block then input prescaler
// - no interrupt on gate transitions
// - counter edge select: none, rise, fall, any
// - block prescaler: 4, 2, 16, 8
// - cpu write beats counting same cycle
// - external direction disconnected when enable 0
module ctud_core_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_count_gate_input,
  input wire logic core_ext_dir_pin,
  output logic toggle_output_pin,
  output logic core_wrap_pulse,
  output logic aux_toggle_latch,
  output logic aux_shadow_latch,
  output logic aux_remote_run
);
  logic [15:0] core_timer_control;
  logic [15:0] core_timer;
  logic overflow_toggle_latch;
  logic shadow_latch;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [4:0] block_cnt;
  logic [7:0] input_cnt;
  logic gate_prev;
  logic block_tick;
  logic prescale_tick;
  logic count_edge;
  logic count_step;
  logic core_dir_bit;
  logic core_run_bit;
  logic [2:0] core_mode_field;
  logic [2:0] core_input_select;
  logic core_ext_dir_enable;
  logic toggle_output_enable;
  logic aux_remote_run_select;
  logic [1:0] block_prescaler_field;
  logic count_down;
  logic gate_open;
  logic wrap;
  logic do_write;
  logic wr_ctrl;
  logic wr_count;
  logic [15:0] wr_val16;
  logic [15:0] next_core_timer;
  logic [4:0] block_div_mask;
  logic [7:0] input_div_mask;

  assign core_dir_bit = core_timer_control[ctud_pkg::dir_pos];
  assign core_run_bit = core_timer_control[ctud_pkg::run_pos];
  assign core_mode_field = core_timer_control[ctud_pkg::mode_lsb +: 3];
  assign core_input_select = core_timer_control[ctud_pkg::input_sel_lsb +: 3];
  assign core_ext_dir_enable = core_timer_control[ctud_pkg::ext_dir_en_pos];
  assign toggle_output_enable = core_timer_control[ctud_pkg::out_en_pos];
  assign aux_remote_run_select = core_timer_control[ctud_pkg::aux_remote_pos];
  assign block_prescaler_field = core_timer_control[ctud_pkg::bps_lsb +: 2];

  // direction from software bit, optionally the pin
  assign count_down = core_ext_dir_enable ? (core_ext_dir_pin ^ core_dir_bit)
    : core_dir_bit;

  // block prescaler divide mask
  always_comb
  begin
    case (ctud_pkg::ctud_bps_t'(block_prescaler_field))
      ctud_pkg::ctud_bps_div4: block_div_mask = 5'h03;
      ctud_pkg::ctud_bps_div2: block_div_mask = 5'h01;
      ctud_pkg::ctud_bps_div16: block_div_mask = 5'h0F;
      ctud_pkg::ctud_bps_div8: block_div_mask = 5'h07;
      default: block_div_mask = 5'h03;
    endcase
  end

  // input prescaler divides by 2 to the input select
  assign input_div_mask = 8'(({8'h00, 1'b1} << core_input_select) - 9'h001);
  assign block_tick = ((block_cnt & block_div_mask) == block_div_mask);
  assign prescale_tick = block_tick && ((input_cnt & input_div_mask) == input_div_mask);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      block_cnt <= 5'h00;
      input_cnt <= 8'h00;
    end
    else
    begin
      block_cnt <= block_cnt + 5'h01;
      if (block_tick)
        input_cnt <= input_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      gate_prev <= 1'b0;
    else
      gate_prev <= core_count_gate_input;
  end

  // counter edge select; assumes source holds levels long enough
  always_comb
  begin
    case (core_input_select)
      ctud_pkg::edge_rise: count_edge = core_count_gate_input && !gate_prev;
      ctud_pkg::edge_fall: count_edge = !core_count_gate_input && gate_prev;
      ctud_pkg::edge_any: count_edge = core_count_gate_input != gate_prev;
      default: count_edge = 1'b0;
    endcase
  end

  // gate level picked by mode bit 3
  assign gate_open = (core_count_gate_input == core_mode_field[0]);

  always_comb
  begin
    case (core_mode_field)
      ctud_pkg::mode_timer: count_step = core_run_bit && prescale_tick;
      ctud_pkg::mode_counter: count_step = core_run_bit && count_edge;
      ctud_pkg::mode_gate_low, ctud_pkg::mode_gate_high:
        count_step = core_run_bit && gate_open && prescale_tick;
      default: count_step = 1'b0;
    endcase
  end

  assign wrap = count_step && (count_down ? (core_timer == 16'h0000)
    : (core_timer == 16'hFFFF));

  // axi write path
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = do_write && (aw_addr == ctud_pkg::ctrl_off);
  assign wr_count = do_write && (aw_addr == ctud_pkg::count_off);
  assign wr_val16 = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ctud_pkg::resp_okay;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_count || aw_addr == ctud_pkg::status_off)
          ? ctud_pkg::resp_okay : ctud_pkg::resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control register, byte lanes honoured
  always_ff @(posedge mclk)
  begin
    if (rst)
      core_timer_control <= ctud_pkg::ctrl_reset;
    else if (wr_ctrl)
    begin
      if (w_strb[0])
        core_timer_control[7:0] <= w_data[7:0];
      if (w_strb[1])
        core_timer_control[15:8] <= w_data[15:8];
    end
    else if (wrap)
      core_timer_control[ctud_pkg::toggle_pos] <= !overflow_toggle_latch;
  end

  assign overflow_toggle_latch = core_timer_control[ctud_pkg::toggle_pos];

  // shadow latch: follows latch, loaded with it on software write
  always_ff @(posedge mclk)
  begin
    if (rst)
      shadow_latch <= 1'b0;
    else if (wr_ctrl && w_strb[1])
      shadow_latch <= w_data[ctud_pkg::toggle_pos];
    else
      shadow_latch <= overflow_toggle_latch;
  end

  // counter; cpu write wins over counting
  always_comb
  begin
    next_core_timer = core_timer;
    if (wr_count)
      next_core_timer = (core_timer & {w_strb[1] ? 8'h00 : 8'hFF, w_strb[0] ? 8'h00 : 8'hFF})
        | wr_val16;
    else if (count_step)
      next_core_timer = count_down ? core_timer - 16'h0001 : core_timer + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      core_timer <= ctud_pkg::count_reset;
    else
      core_timer <= next_core_timer;
  end

  // outputs, all registered; no interrupt logic
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      toggle_output_pin <= 1'b1;
      core_wrap_pulse <= 1'b0;
      aux_toggle_latch <= 1'b0;
      aux_shadow_latch <= 1'b0;
      aux_remote_run <= 1'b0;
    end
    else
    begin
      toggle_output_pin <= toggle_output_enable ? overflow_toggle_latch : 1'b1;
      core_wrap_pulse <= wrap && !wr_count;
      aux_toggle_latch <= overflow_toggle_latch;
      aux_shadow_latch <= shadow_latch;
      aux_remote_run <= aux_remote_run_select && core_run_bit;
    end
  end

  // axi read path
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ctud_pkg::resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ctud_pkg::resp_okay;
        case (s_axi_araddr)
          ctud_pkg::ctrl_off: s_axi_rdata <= {16'h0000, core_timer_control};
          ctud_pkg::count_off: s_axi_rdata <= {16'h0000, core_timer};
          ctud_pkg::status_off: s_axi_rdata <= {29'h00000000, count_down, shadow_latch,
            overflow_toggle_latch};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ctud_pkg::resp_slverr;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ctud_core_timer

// file: hdl/ctud_pkg.sv
// Purpose: shared constants for the core up/down timer
// Assumes: axi4-lite register access, 32-bit data
// Notes: register offsets are byte addresses
package ctud_pkg;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] count_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam int input_sel_lsb = 0;
  localparam int mode_lsb = 3;
  localparam int run_pos = 6;
  localparam int dir_pos = 7;
  localparam int ext_dir_en_pos = 8;
  localparam int out_en_pos = 9;
  localparam int toggle_pos = 10;
  localparam int bps_lsb = 11;
  localparam int aux_remote_pos = 13;
  localparam logic [2:0] mode_timer = 3'h0;
  localparam logic [2:0] mode_counter = 3'h1;
  localparam logic [2:0] mode_gate_low = 3'h2;
  localparam logic [2:0] mode_gate_high = 3'h3;
  localparam logic [2:0] edge_none = 3'h0;
  localparam logic [2:0] edge_rise = 3'h1;
  localparam logic [2:0] edge_fall = 3'h2;
  localparam logic [2:0] edge_any = 3'h3;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {ctud_bps_div4, ctud_bps_div2, ctud_bps_div16, ctud_bps_div8} ctud_bps_t;
endpackage : ctud_pkg

// file: test/ctud_far_side.sv
// Purpose: far-side pin model
// Assumes: changes follow mclk edges
// Notes: hold paces the edges
module ctud_far_side (
  input wire logic mclk,
  output logic core_count_gate_input,
  output logic core_ext_dir_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 2;
  initial
  begin
    core_count_gate_input = 1'b0;
    core_ext_dir_pin = 1'b0;
  end
  task automatic set(input logic g, input logic p);
    core_count_gate_input <= g;
    core_ext_dir_pin <= p;
  endtask : set
  task automatic pulses(input int n);
    repeat (2 * n)
    begin
      repeat (hold) @(posedge mclk);
      core_count_gate_input <= ~core_count_gate_input;
    end
    repeat (hold) @(posedge mclk);
  endtask : pulses
endmodule : ctud_far_side

// file: test/ctud_core_timer_assertions.sv
// Purpose: port checker
// Assumes: one clock, sync reset
// Notes: bound to the timer module
module ctud_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic toggle_output_pin,
  input wire logic core_wrap_pulse,
  input wire logic aux_toggle_latch,
  input wire logic aux_shadow_latch,
  input wire logic aux_remote_run
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_split;
    aux_toggle_latch != aux_shadow_latch;
  endsequence
  property p_wr; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("late write reply");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("late read reply");
  property p_rst;
    disable iff (1'b0) rst |=> toggle_output_pin && !aux_remote_run && !core_wrap_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_shadow; s_split |=> aux_shadow_latch == $past(aux_toggle_latch); endproperty
  a_shadow: assert property (p_shadow) else $error("shadow lag wrong");
  property p_brief; s_split |=> aux_shadow_latch == aux_toggle_latch; endproperty
  a_brief: assert property (p_brief) else $error("split too long");
  property p_wrap; core_wrap_pulse |-> ##[0:2] s_split; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without toggle");
  property p_pulse; core_wrap_pulse |=> !core_wrap_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("wrap pulse too long");
  property p_pin; !toggle_output_pin |-> !aux_toggle_latch; endproperty
  a_pin: assert property (p_pin) else $error("pin low, latch high");
endmodule : ctud_chk
bind ctud_core_timer ctud_chk u_chk (.*);

// file: test/core_timer_updown_toggle_bench.sv
// Purpose: core timer bench
// Assumes: axi4-lite master, pin model
// Notes: counter rows give exact counts
module core_timer_updown_toggle_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] rows [9] = '{36'h1_0049_0003, 36'h0_004A_0003, 36'h0_004B_0006,
    36'h0_0048_0000, 36'h0_0009_0000, 36'h0_00C9_FFFD, 36'h1_0149_FFFD,
    36'h1_01C9_0003, 36'h0_0061_0000};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_count_gate_input, core_ext_dir_pin, toggle_output_pin, core_wrap_pulse;
  logic aux_toggle_latch, aux_shadow_latch, aux_remote_run;
  int n_fail = 0, checks_done = 0, n, dv [4] = '{4, 2, 16, 8};
  ctud_core_timer u_dut (.s_axi_wstrb(4'hF), .*);
  ctud_far_side u_far (.*);
  always #2.5 mclk = ~mclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(ctud_pkg::ctrl_off);
    chk(d, 32'h0);
    rd(8'h0C);
    chk({d[29:0], rs}, 32'h2);
    foreach (rows[i])
    begin
      u_far.hold = 2 + i % 3;
      wr(ctud_pkg::ctrl_off, 32'h0);
      wr(ctud_pkg::count_off, 32'h0);
      u_far.set(1'b0, rows[i][32]);
      wr(ctud_pkg::ctrl_off, {16'h0, rows[i][31:16]});
      u_far.pulses(3);
      rd(ctud_pkg::count_off);
      chk(d, {16'h0, rows[i][15:0]});
    end
    wr(ctud_pkg::ctrl_off, 32'h0600);
    rd(ctud_pkg::status_off);
    chk(d, 32'h3);
    chk(32'({aux_toggle_latch, aux_shadow_latch, toggle_output_pin}), 32'h7);
    wr(ctud_pkg::ctrl_off, 32'h2240);
    rd(ctud_pkg::status_off);
    chk(32'({aux_remote_run, toggle_output_pin}), 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      wr(ctud_pkg::ctrl_off, 32'h0);
      u_far.set(k[0], 1'b0);
      wr(ctud_pkg::count_off, 32'h0);
      wr(ctud_pkg::ctrl_off, {28'h5, k[1], 3'h0});
      repeat (40) @(posedge mclk);
      rd(ctud_pkg::count_off);
      chk(32'(d != 0), 32'(k[0] == k[1]));
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(ctud_pkg::ctrl_off, 32'h0);
      wr(ctud_pkg::count_off, 32'hFFF0);
      wr(ctud_pkg::ctrl_off, {19'h0, 2'(b), 11'h040});
      for (n = 0; n < 400 && core_wrap_pulse !== 1'b1; n++)
        @(posedge mclk);
      chk(32'(n >= 14 * dv[b] && n <= 16 * dv[b] + 6), 32'h1);
    end
    // mid-run reset while the timer runs
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(32'({aux_remote_run, toggle_output_pin, core_wrap_pulse, aux_toggle_latch}), 32'h4);
    rd(ctud_pkg::ctrl_off);
    chk(d, 32'h0);
    rd(ctud_pkg::count_off);
    chk(d, 32'h0);
    final_report();
  end
  initial
  begin
    #100us;
    n_fail++;
    final_report();
  end
endmodule : core_timer_updown_toggle_bench
